// File: src/mac_test_defs.vh
// Opcodes, cycle counts and flag bit positions of the MAC transfer
// and zero-or-minus test datapath. Definitions only.
`ifndef MAC_TEST_DEFS_VH
`define MAC_TEST_DEFS_VH

// Opcodes; single-byte page-0 opcodes arrive zero-extended to 16 bits
`define OP_MAC_TO_E_TRUNC  16'h27B5
`define OP_MAC_SPLIT       16'h27B3
`define OP_MEM_TEST_X8     16'h0006
`define OP_MEM_TEST_Y8     16'h0016
`define OP_MEM_TEST_Z8     16'h0026
`define OP_MEM_TEST_X16    16'h1706
`define OP_MEM_TEST_Y16    16'h1716
`define OP_MEM_TEST_Z16    16'h1726
`define OP_MEM_TEST_ABS    16'h1736
`define OP_ACC_A_TEST      16'h3706
`define OP_ACC_B_TEST      16'h3716
`define OP_ACC_D_TEST      16'h27F6
`define OP_ACC_E_TEST      16'h2776

// Instruction lengths in clock cycles
`define CYC_TRUNC          3'd2
`define CYC_SPLIT          3'd6
`define CYC_MEM_TEST       3'd6
`define CYC_ACC_TEST       3'd2

// Condition code register bit positions
`define CC_MAC_OVF         14
`define CC_GUARD_OVF       12
`define CC_N               11
`define CC_Z               10
`define CC_V               9
`define CC_C               8
`define CC_SAT_MODE        4

// Saturation values for accumulator E
`define SAT_POS            16'h7FFF
`define SAT_NEG            16'h8000

`endif

// File: src/nz_flags.v
// Negative and zero flags of a value compared against zero.
// Purely combinational; the caller registers the result.
module nz_flags #(
  parameter W = 16
) (
  input  wire [W-1:0] value_i,
  input  wire         wide_i,
  output wire         neg_o,
  output wire         zero_o
);

  // Narrow mode looks at the low byte only
  assign neg_o  = wide_i ? value_i[W-1] : value_i[7];
  assign zero_o = wide_i ? (value_i == {W{1'b0}}) : (value_i[7:0] == 8'h00);

endmodule

// File: src/mac_transfer_test_ops.v
// Execution datapath for the MAC-to-register transfers and the
// zero-or-minus tests. Assumes the decoder presents one opcode with a
// start pulse while idle, plus current register and operand values, and
// commits the write-back strobes it receives on completion.
//
// Overview of operation
// RULE1 - Opcode 27B5 moves MAC to E in 2 cycles, changing only N and Z.
// RULE2 - Saturate mode plus either overflow flag: E gets saturation value.
// RULE3 - Otherwise E gets MAC bits 31:16; low sixteen bits are discarded.
// RULE4 - Opcode 27B3, 6 cycles: X gets extended 35:32, E 31:16, no flags.
// RULE5 - The split move also puts MAC bits 15:0 into D.
// RULE6 - Byte tests set N, Z, clear V, C; memory forms 6 cycles, A/B 2.
// RULE7 - Tests of D (27F6) and E (2776) take 2 cycles, set N, Z, clear V, C.
// RULE8 - Condition code bits an operation does not name keep their value.
`include "mac_test_defs.vh"

module mac_transfer_test_ops (
  input  wire        mclk_i,
  input  wire        rstn_i,
  input  wire        start_i,
  input  wire [15:0] opcode_i,
  input  wire [35:0] mac_accumulator_i,
  input  wire [15:0] condition_code_register_i,
  input  wire [7:0]  acc_a_i,
  input  wire [7:0]  acc_b_i,
  input  wire [15:0] acc_e_i,
  input  wire [7:0]  mem_operand_i,
  output reg         busy_o,
  output reg         done_o,
  output reg         illegal_o,
  output reg  [15:0] e_data_o,
  output reg         e_we_o,
  output reg  [15:0] d_data_o,
  output reg         d_we_o,
  output reg  [15:0] index_x_o,
  output reg         index_x_we_o,
  output reg  [15:0] condition_code_o,
  output reg         condition_code_we_o
);

  localparam ST_IDLE = 1'b0;
  localparam ST_RUN  = 1'b1;

  reg        state_q;
  reg        state_d;
  reg [2:0]  cnt_q;
  reg [2:0]  cnt_d;

  // Results computed at issue, held until the final cycle
  reg [15:0] e_res_q;
  reg [15:0] d_res_q;
  reg [15:0] x_res_q;
  reg [15:0] cc_res_q;
  reg        e_wr_q;
  reg        d_wr_q;
  reg        x_wr_q;
  reg        cc_wr_q;

  reg [15:0] e_res_d;
  reg [15:0] d_res_d;
  reg [15:0] x_res_d;
  reg [15:0] cc_res_d;
  reg        e_wr_d;
  reg        d_wr_d;
  reg        x_wr_d;
  reg        cc_wr_d;
  reg [2:0]  cyc;
  reg        legal;
  reg [15:0] test_val;
  reg        test_wide;
  reg        set_nz_vc;
  reg [15:0] trunc_val;

  wire       sat_mode;
  wire       ovf_any;
  wire       neg_w;
  wire       zero_w;

  assign sat_mode = condition_code_register_i[`CC_SAT_MODE];
  assign ovf_any  = condition_code_register_i[`CC_GUARD_OVF] |
                    condition_code_register_i[`CC_MAC_OVF];

  nz_flags #(
    .W (16)
  ) u_nz (
    .value_i (test_val),
    .wide_i  (test_wide),
    .neg_o   (neg_w),
    .zero_o  (zero_w)
  );

  // Operand steering kept apart from decode to avoid a flag loop
  always @* begin
    test_val  = 16'h0000;
    test_wide = 1'b1;
    if (sat_mode && ovf_any) begin
      trunc_val = mac_accumulator_i[35] ? `SAT_NEG : `SAT_POS; // [RULE2]
    end else begin
      trunc_val = mac_accumulator_i[31:16]; // [RULE3]
    end
    case (opcode_i)
      `OP_MAC_TO_E_TRUNC: begin
        test_val = trunc_val;
      end
      `OP_MEM_TEST_X8, `OP_MEM_TEST_Y8, `OP_MEM_TEST_Z8,
      `OP_MEM_TEST_X16, `OP_MEM_TEST_Y16, `OP_MEM_TEST_Z16,
      `OP_MEM_TEST_ABS: begin
        test_val  = {8'h00, mem_operand_i};
        test_wide = 1'b0;
      end
      `OP_ACC_A_TEST: begin
        test_val  = {8'h00, acc_a_i};
        test_wide = 1'b0;
      end
      `OP_ACC_B_TEST: begin
        test_val  = {8'h00, acc_b_i};
        test_wide = 1'b0;
      end
      `OP_ACC_D_TEST: begin
        test_val = {acc_a_i, acc_b_i};
      end
      `OP_ACC_E_TEST: begin
        test_val = acc_e_i;
      end
      default: begin
        test_val = 16'h0000;
      end
    endcase
  end

  // Decode and result formation
  always @* begin
    cyc       = 3'd0;
    legal     = 1'b1;
    set_nz_vc = 1'b0;
    e_wr_d    = 1'b0;
    d_wr_d    = 1'b0;
    x_wr_d    = 1'b0;
    cc_wr_d   = 1'b0;
    e_res_d   = acc_e_i;
    d_res_d   = {acc_a_i, acc_b_i};
    x_res_d   = 16'h0000;
    // Untouched flags pass through unchanged
    cc_res_d  = condition_code_register_i; // [RULE8]
    case (opcode_i)
      `OP_MAC_TO_E_TRUNC: begin
        cyc      = `CYC_TRUNC; // [RULE1]
        e_res_d  = trunc_val;
        e_wr_d   = 1'b1;
        cc_wr_d  = 1'b1;
        cc_res_d[`CC_N] = neg_w; // [RULE1]
        cc_res_d[`CC_Z] = zero_w;
      end
      `OP_MAC_SPLIT: begin
        cyc     = `CYC_SPLIT; // [RULE4]
        x_res_d = {{12{mac_accumulator_i[35]}},
                   mac_accumulator_i[35:32]}; // [RULE4]
        e_res_d = mac_accumulator_i[31:16]; // [RULE4]
        d_res_d = mac_accumulator_i[15:0]; // [RULE5]
        x_wr_d  = 1'b1;
        e_wr_d  = 1'b1;
        d_wr_d  = 1'b1;
      end
      `OP_MEM_TEST_X8, `OP_MEM_TEST_Y8, `OP_MEM_TEST_Z8,
      `OP_MEM_TEST_X16, `OP_MEM_TEST_Y16, `OP_MEM_TEST_Z16,
      `OP_MEM_TEST_ABS: begin
        cyc       = `CYC_MEM_TEST; // [RULE6]
        set_nz_vc = 1'b1;
      end
      `OP_ACC_A_TEST, `OP_ACC_B_TEST: begin
        cyc       = `CYC_ACC_TEST; // [RULE6]
        set_nz_vc = 1'b1;
      end
      `OP_ACC_D_TEST, `OP_ACC_E_TEST: begin
        cyc       = `CYC_ACC_TEST; // [RULE7]
        set_nz_vc = 1'b1;
      end
      default: begin
        legal = 1'b0;
      end
    endcase
    if (set_nz_vc) begin
      // Subtracting zero never borrows or overflows
      cc_wr_d         = 1'b1;
      cc_res_d[`CC_N] = neg_w; // [RULE6] [RULE7]
      cc_res_d[`CC_Z] = zero_w;
      cc_res_d[`CC_V] = 1'b0;
      cc_res_d[`CC_C] = 1'b0;
    end
  end

  // Sequencer
  always @* begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      ST_IDLE: begin
        if (start_i && legal) begin
          state_d = ST_RUN;
          cnt_d   = cyc - 3'd1;
        end
      end
      ST_RUN: begin
        cnt_d = cnt_q - 3'd1;
        if (cnt_q == 3'd1) begin
          state_d = ST_IDLE;
          cnt_d   = 3'd0;
        end
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d   = 3'd0;
      end
    endcase
  end

  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q             <= ST_IDLE;
      cnt_q               <= 3'd0;
      e_res_q             <= 16'h0000;
      d_res_q             <= 16'h0000;
      x_res_q             <= 16'h0000;
      cc_res_q            <= 16'h0000;
      e_wr_q              <= 1'b0;
      d_wr_q              <= 1'b0;
      x_wr_q              <= 1'b0;
      cc_wr_q             <= 1'b0;
      busy_o              <= 1'b0;
      done_o              <= 1'b0;
      illegal_o           <= 1'b0;
      e_data_o            <= 16'h0000;
      e_we_o              <= 1'b0;
      d_data_o            <= 16'h0000;
      d_we_o              <= 1'b0;
      index_x_o           <= 16'h0000;
      index_x_we_o        <= 1'b0;
      condition_code_o    <= 16'h0000;
      condition_code_we_o <= 1'b0;
    end else begin
      state_q             <= state_d;
      cnt_q               <= cnt_d;
      done_o              <= 1'b0;
      illegal_o           <= 1'b0;
      e_we_o              <= 1'b0;
      d_we_o              <= 1'b0;
      index_x_we_o        <= 1'b0;
      condition_code_we_o <= 1'b0;
      if (state_q == ST_IDLE && start_i) begin
        illegal_o <= ~legal;
        if (legal) begin
          busy_o   <= 1'b1;
          e_res_q  <= e_res_d;
          d_res_q  <= d_res_d;
          x_res_q  <= x_res_d;
          cc_res_q <= cc_res_d;
          e_wr_q   <= e_wr_d;
          d_wr_q   <= d_wr_d;
          x_wr_q   <= x_wr_d;
          cc_wr_q  <= cc_wr_d;
        end
      end
      // Write-back in the last cycle of the instruction
      if (state_q == ST_RUN && cnt_q == 3'd1) begin
        busy_o              <= 1'b0;
        done_o              <= 1'b1;
        e_data_o            <= e_res_q;
        e_we_o              <= e_wr_q;
        d_data_o            <= d_res_q;
        d_we_o              <= d_wr_q;
        index_x_o           <= x_res_q;
        index_x_we_o        <= x_wr_q;
        condition_code_o    <= cc_res_q;
        condition_code_we_o <= cc_wr_q; // [RULE4]
      end
    end
  end

endmodule

// File: testbench/mac_test_checker.sv
// Checker for the MAC transfer and zero-or-minus test datapath.
// Assumes it is bound to mac_transfer_test_ops and sees its ports only.
module mac_test_checker (
  input logic        mclk_i,
  input logic        rstn_i,
  input logic        start_i,
  input logic [15:0] opcode_i,
  input logic [35:0] mac_accumulator_i,
  input logic [15:0] condition_code_register_i,
  input logic        busy_o,
  input logic        done_o,
  input logic [15:0] e_data_o,
  input logic        e_we_o,
  input logic [15:0] d_data_o,
  input logic        d_we_o,
  input logic [15:0] index_x_o,
  input logic        index_x_we_o,
  input logic [15:0] condition_code_o,
  input logic        condition_code_we_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  wire        go  = start_i && !busy_o;
  wire [15:0] cc  = condition_code_register_i;
  wire [35:0] mac = mac_accumulator_i;
  wire        sat = cc[4] && (cc[12] || cc[14]);
  wire [15:0] sv  = mac[35] ? 16'h8000 : 16'h7FFF;
  wire [15:0] ahi = {{12{mac[35]}}, mac[35:32]};
  wire [15:0] amd = mac[31:16];
  wire [15:0] alo = mac[15:0];
  wire        tr  = go && opcode_i == 16'h27B5;
  wire        sp  = go && opcode_i == 16'h27B3;
  a_trunc_timing: assert property (
    tr |=> !done_o ##1 (done_o && e_we_o && condition_code_we_o && !d_we_o))
    else $error("truncated move write-back timing");
  a_trunc_sat: assert property (
    tr && sat |-> ##2 e_data_o == $past(sv, 2))
    else $error("truncated move saturation value");
  a_trunc_copy: assert property (
    tr && !sat |-> ##2 e_data_o == $past(amd, 2))
    else $error("truncated move copy of upper half");
  a_trunc_flags_kept: assert property (
    tr |-> ##2 (condition_code_o & 16'hF3FF) == ($past(cc, 2) & 16'hF3FF))
    else $error("truncated move touched other flags");
  a_split_timing: assert property (
    sp |=> busy_o[*5] ##1 (done_o && e_we_o && d_we_o && index_x_we_o
                           && !condition_code_we_o))
    else $error("split move timing or strobes");
  a_split_values: assert property (
    sp |-> ##6 index_x_o == $past(ahi, 6) && e_data_o == $past(amd, 6)
               && d_data_o == $past(alo, 6))
    else $error("split move values");
  a_test_vc_clear: assert property (
    condition_code_we_o && !e_we_o |-> condition_code_o[9:8] == 2'b00)
    else $error("test left V or C set");
  a_mem_test_six: assert property (
    go && opcode_i == 16'h1736 |=> !done_o[*5] ##1
      (done_o && condition_code_we_o && !e_we_o))
    else $error("memory test timing");
  a_dtest_kept: assert property (
    go && opcode_i == 16'h27F6 |-> ##2
      (condition_code_o & 16'hF0FF) == ($past(cc, 2) & 16'hF0FF))
    else $error("D test touched other flags");
endmodule

bind mac_transfer_test_ops mac_test_checker u_chk (.mclk_i, .rstn_i,
  .start_i, .opcode_i, .mac_accumulator_i, .condition_code_register_i,
  .busy_o, .done_o, .e_data_o, .e_we_o, .d_data_o, .d_we_o, .index_x_o,
  .index_x_we_o, .condition_code_o, .condition_code_we_o);

// File: testbench/tb.sv
// Self-checking bench for mac_transfer_test_ops.
// Assumes a 200 MHz clock and inputs changed 1 ns after the rising edge.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i, rstn_i, start_i;
  logic [15:0] opcode_i, condition_code_register_i, acc_e_i;
  logic [35:0] mac_accumulator_i;
  logic [7:0]  acc_a_i, acc_b_i, mem_operand_i;
  logic        busy_o, done_o, illegal_o, e_we_o, d_we_o;
  logic        index_x_we_o, condition_code_we_o;
  logic [15:0] e_data_o, d_data_o, index_x_o, condition_code_o;
  logic [15:0] op, opnd, cc, xcc, xe;
  logic [35:0] mac;
  int          n_fail, tests_run, ncyc;
  // Opcode, operand, MAC, flags in, flags out, E out
  localparam logic [115:0] ROWS [17] = '{
    116'h0006_0080_000000000_0000_0800_0000,
    116'h0016_FF00_000000000_0300_0400_0000,
    116'h0026_007F_000000000_F0FF_F0FF_0000,
    116'h1706_0001_000000000_0C00_0000_0000,
    116'h1716_00FF_000000000_0000_0800_0000,
    116'h1726_0000_000000000_0800_0400_0000,
    116'h1736_0080_000000000_0000_0800_0000,
    116'h3706_0080_000000000_0B00_0400_0000,
    116'h3716_8040_000000000_0000_0000_0000,
    116'h27F6_0080_000000000_0800_0000_0000,
    116'h27F6_0000_000000000_0300_0400_0000,
    116'h2776_8000_000000000_0000_0800_0000,
    116'h27B5_0000_912345678_0000_0000_1234,
    116'h27B5_0000_100000000_1010_1010_7FFF,
    116'h27B5_0000_800000000_4010_4810_8000,
    116'h27B5_0000_080000000_0010_0810_8000,
    116'h27B5_0000_00000FFFF_5000_5400_0000};

  mac_transfer_test_ops dut (.mclk_i, .rstn_i, .start_i, .opcode_i,
    .mac_accumulator_i, .condition_code_register_i, .acc_a_i, .acc_b_i,
    .acc_e_i, .mem_operand_i, .busy_o, .done_o, .illegal_o, .e_data_o,
    .e_we_o, .d_data_o, .d_we_o, .index_x_o, .index_x_we_o,
    .condition_code_o, .condition_code_we_o);

  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask

  // A and B take the operand halves, E and memory the whole and low byte
  task automatic drive(input logic [15:0] o, d, input logic [35:0] m,
                       input logic [15:0] c);
    opcode_i = o;
    acc_a_i = d[15:8];
    acc_b_i = d[7:0];
    acc_e_i = d;
    mem_operand_i = d[7:0];
    mac_accumulator_i = m;
    condition_code_register_i = c;
    start_i = 1'b1;
    @(posedge mclk_i);
    #1 start_i = 1'b0;
  endtask

  task automatic waitdone(input int k0);
    ncyc = k0;
    while (done_o !== 1'b1) begin
      if (ncyc >= 20) begin
        chk(1'b0, "no completion");
        summarize;
      end
      @(posedge mclk_i);
      #1 ncyc++;
    end
  endtask

  initial begin
    n_fail = 0;
    tests_run = 0;
    rstn_i = 1'b0;
    {start_i, opcode_i, mac_accumulator_i, condition_code_register_i,
     acc_a_i, acc_b_i, acc_e_i, mem_operand_i} = '0;
    repeat (2) @(posedge mclk_i);
    #1 rstn_i = 1'b1;
    chk(busy_o === 1'b0 && done_o === 1'b0 && illegal_o === 1'b0 &&
        e_data_o === 16'h0000 && condition_code_o === 16'h0000, "reset");
    foreach (ROWS[i]) begin
      {op, opnd, mac, cc, xcc, xe} = ROWS[i];
      drive(op, opnd, mac, cc);
      waitdone(1);
      chk(ncyc == ((op[15:8] == 8'h00 || op[15:8] == 8'h17) ? 6 : 2),
          "cycle count");
      chk(condition_code_we_o === 1'b1 && condition_code_o === xcc,
          "flags");
      chk(e_we_o === (op == 16'h27B5) && d_we_o === 1'b0 &&
          index_x_we_o === 1'b0, "strobes");
      if (op == 16'h27B5) chk(e_data_o === xe, "E value");
    end
    // Split move with a start while busy that must be ignored
    drive(16'h27B3, 16'h0000, 36'hA87654321, 16'h0F00);
    @(posedge mclk_i);
    #1 opcode_i = 16'h3706;
    start_i = 1'b1;
    @(posedge mclk_i);
    #1 start_i = 1'b0;
    waitdone(3);
    chk(ncyc == 6 && condition_code_we_o === 1'b0, "split timing");
    chk(index_x_o === 16'hFFFA && index_x_we_o === 1'b1 &&
        e_data_o === 16'h8765 && e_we_o === 1'b1, "split X E");
    chk(d_data_o === 16'h4321 && d_we_o === 1'b1, "split D");
    repeat (3) begin
      @(posedge mclk_i);
      #1 chk(done_o === 1'b0, "ignored start ran");
    end
    drive(16'h1234, 16'h0000, 36'h000000000, 16'h0000);
    chk(illegal_o === 1'b1 && busy_o === 1'b0, "unknown opcode");
    @(posedge mclk_i);
    #1 drive(16'h2776, 16'h0001, 36'h000000000, 16'h0000);
    rstn_i = 1'b0;
    #1 chk(busy_o === 1'b0 && done_o === 1'b0, "reset in flight");
    @(posedge mclk_i);
    #1 rstn_i = 1'b1;
    @(posedge mclk_i);
    #1 chk(done_o === 1'b0 && condition_code_we_o === 1'b0, "after reset");
    summarize;
  end
endmodule
